/* hdl/e1_rx_status_words.sv */
// Receive status words of an E1 framer, sent on channels 17-21 of the control stream.
// Assumes framer status inputs are on sys_clk_in; bus clock and pins are asynchronous.
//
// Overview of operation
// - Non-alignment bit one goes to bit 7.
// - Non-alignment marker bit goes to bit 6.
// - Remote alarm bit goes to bit 5.
// - National use bits go to bits 4-0.
// - Status one bit 7 flags frame loss.
// - Status one bit 6 flags multiframe loss.
// - Alignment error bit toggles per 16, 128 ms.
// - Count errors only in alignment frames.
// - Status one bit 4 toggles per slip.
// - Status one bit 3 shows all-ones alarm.
// - Status one bit 2 shows slot-16 all-ones.
// - External pin sampled per frame, bit 1.
// - Phase word: slot and bit to 8k edge.
// - Phase ninth bit toggles on wraparound.
// - Eight-bit CRC error tally wraps at 256.
// - Maintenance resets tally every second.
// - Spare bits latched per multiframe pulse.
// - Second marker high 8 ms, falls at interval.
// - Reframe flag if no CRC lock in 8 ms.
// - Reframe clears on CRC lock or no maintenance.
// - Status two bit 1 low when CRC locked.
`timescale 1ns/1ps
`include "e1_rx_status_regs.svh"
module e1_rx_status_words #(
  parameter logic [31:0] ERR_HOLD_CYCLES = `ERR_HOLD_MS * `CLK_KHZ,
  parameter logic [31:0] MARKER_CYCLES   = `CRC_MARKER_MS * `CLK_KHZ,
  parameter logic [31:0] REFRAME_CYCLES  = `REFRAME_MS * `CLK_KHZ,
  parameter logic [31:0] SECOND_CYCLES   = `CRC_INTERVAL_MS * `CLK_KHZ
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  // Bus timing and pins, asynchronous
  input  wire logic       bus_bit_clk_in,
  input  wire logic       bus_frame_pulse_n_in,
  input  wire logic       extracted_8k_in,
  input  wire logic       external_status_in,
  // Timeslot zero bytes from the framer
  input  wire logic [7:0] ts0_byte_in,
  input  wire logic       ts0_valid_in,
  input  wire logic       ts0_is_align_in,
  // Framer state
  input  wire logic       frame_sync_loss_in,
  input  wire logic       multiframe_sync_loss_in,
  input  wire logic       slip_pulse_in,
  input  wire logic       rx_all_ones_alarm_in,
  input  wire logic       rx_sig_slot_all_ones_in,
  input  wire logic       crc_locked_in,
  input  wire logic       crc_error_pulse_in,
  input  wire logic       rx_multiframe_pulse_in,
  input  wire logic       spare_bit_frame15_in,
  input  wire logic       spare_bit_frame13_in,
  input  wire logic [7:0] control_word_three_in,
  // Control stream
  output logic            control_out_stream_out,
  output logic            control_out_stream_oe_out
);

  localparam int NSYNC = 4;  // Asynchronous pins
  localparam logic [NSYNC-1:0] SYNC_IDLE = 4'b0010;  // Idle pin levels: no false frame after reset
  logic [NSYNC-1:0] pin_raw;    // Pins as they arrive
  logic [NSYNC-1:0] sync1_r;    // First stage, read by stage two only
  logic [NSYNC-1:0] sync2_r;    // Safe copies
  logic [NSYNC-1:0] sync3_r;    // Delayed copies for edges
  logic             bit_rise;   // Bus bit clock rising edge
  logic             k8_rise;    // Extracted 8 kHz rising edge
  logic             fp_low;     // Frame pulse active
  logic             ext_pin;    // External status level

  logic [7:0]       pos_r;      // Bus position: slot and bit
  logic [7:0]       pos_nxt;    // Position that starts now
  logic             frame_start;  // First bit of a bus frame
  e1_rx_status_pkg::status_bytes_type bytes;  // Assembled bytes
  logic [7:0]       nonalign_r;     // Last non-alignment byte
  logic [4:0]       err_cnt_r;      // Errored alignment bytes
  logic             align_err_r;    // Toggling error bit
  logic             hold_idle;      // 128 ms holdoff over
  logic             err_toggle;     // Toggle fires now
  logic             slip_r;         // Toggling slip bit
  logic             ext_sample_r;   // Per-frame pin sample
  logic [7:0]       phase_r;        // Slot and bit at 8k edge
  logic             phase_msb_r;    // Ninth phase bit
  logic [7:0]       tally_r;        // CRC error tally
  logic [31:0]      sec_cnt_r;      // Position in the second
  logic             marker_r;       // Second marker
  logic             interval_go;    // Marker falls now
  logic             spare15_r;      // Spare bit of frame 15
  logic             spare13_r;      // Spare bit of frame 13
  logic             fs_loss_d_r;    // Frame loss one cycle ago
  logic             fs_gain;        // Frame sync just found
  logic             window_idle;    // 8 ms window over
  logic             maint;          // Maintenance option
  logic             align_bad;      // Errored alignment byte

  e1_rx_status_pkg::reframe_state_type rf_state_r;  // Reframe watch

  assign pin_raw = {external_status_in, extracted_8k_in, bus_frame_pulse_n_in, bus_bit_clk_in};

  // Two flip-flops on every pin before any logic sees it
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
          sync1_r[gi] <= SYNC_IDLE[gi];
          sync2_r[gi] <= SYNC_IDLE[gi];
          sync3_r[gi] <= SYNC_IDLE[gi];
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
        end
      end
    end
  endgenerate

  assign bit_rise = sync2_r[0] & ~sync3_r[0];
  assign fp_low   = ~sync2_r[1];
  assign k8_rise  = sync2_r[2] & ~sync3_r[2];
  assign ext_pin  = sync2_r[3];

  assign maint = control_word_three_in[`MAINT_BIT];

  // Frame pulse seen at a bit edge restarts the frame at slot 0 bit 0
  assign pos_nxt     = fp_low ? 8'h00 : pos_r + 8'h01;
  assign frame_start = bit_rise & fp_low;

  // Bus position counter
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pos_r <= 8'h00;
    end else if (bit_rise) begin
      pos_r <= pos_nxt;
    end
  end

  // Keep the latest non-alignment byte whole
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      nonalign_r <= 8'h00;
    end else if (ts0_valid_in && !ts0_is_align_in) begin
      nonalign_r <= ts0_byte_in;
    end
  end

  // Only alignment frames are checked; bit 7 there is not pattern
  assign align_bad  = ts0_valid_in & ts0_is_align_in &
                      (ts0_byte_in[6:0] != `ALIGN_PATTERN);
  assign err_toggle = (err_cnt_r == `ERR_TOGGLE_COUNT) & hold_idle;

  // Count errors; at 16 wait for the holdoff before toggling
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      err_cnt_r   <= 5'h00;
      align_err_r <= 1'b0;
    end else if (err_toggle) begin
      align_err_r <= ~align_err_r;
      // An error in the toggle cycle starts the next batch
      err_cnt_r   <= align_bad ? 5'h01 : 5'h00;
    end else if (align_bad && err_cnt_r != `ERR_TOGGLE_COUNT) begin
      err_cnt_r <= err_cnt_r + 5'h01;
    end
  end

  // Holdoff so the error bit toggles at most once per 128 ms
  interval_timer #(
    .CYCLES (ERR_HOLD_CYCLES)
  ) u_err_hold (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .start_in   (err_toggle),
    .idle_out   (hold_idle)
  );

  // Slip toggle and per-frame external status sample
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      slip_r       <= 1'b0;
      ext_sample_r <= 1'b0;
    end else begin
      if (slip_pulse_in) begin
        slip_r <= ~slip_r;
      end
      if (frame_start) begin
        ext_sample_r <= ext_pin;
      end
    end
  end

  // Phase capture at the 8k edge; the ninth bit follows wraparound
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      phase_r     <= 8'h00;
      phase_msb_r <= 1'b0;
    end else if (k8_rise) begin
      phase_r <= pos_r;
      // Past slot 31 bit 7 going up, or below slot 0 bit 0 going down
      if ((phase_r[7:6] == 2'h3 && pos_r[7:6] == 2'h0) ||
          (phase_r[7:6] == 2'h0 && pos_r[7:6] == 2'h3)) begin
        phase_msb_r <= ~phase_msb_r;
      end
    end
  end

  // One-second frame: marker high for the first 8 ms
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      sec_cnt_r <= 32'h0;
      marker_r  <= 1'b1;
    end else begin
      if (sec_cnt_r == SECOND_CYCLES - 32'h1) begin
        sec_cnt_r <= 32'h0;
        marker_r  <= 1'b1;
      end else begin
        sec_cnt_r <= sec_cnt_r + 32'h1;
        if (interval_go) begin
          marker_r <= 1'b0;
        end
      end
    end
  end

  // Marker falls as the accumulation interval starts
  assign interval_go = marker_r & (sec_cnt_r == MARKER_CYCLES - 32'h1);

  // CRC error tally; an error in the reset cycle is kept
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tally_r <= 8'h00;
    end else if (interval_go && maint) begin
      tally_r <= crc_error_pulse_in ? 8'h01 : 8'h00;
    end else if (crc_error_pulse_in) begin
      tally_r <= tally_r + 8'h01;
    end
  end

  // Spare bits refresh on each multiframe pulse
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      spare15_r <= 1'b0;
      spare13_r <= 1'b0;
    end else if (rx_multiframe_pulse_in) begin
      spare15_r <= spare_bit_frame15_in;
      spare13_r <= spare_bit_frame13_in;
    end
  end

  // Frame sync gain starts the CRC search window
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      fs_loss_d_r <= 1'b1;
    end else begin
      fs_loss_d_r <= frame_sync_loss_in;
    end
  end

  assign fs_gain = fs_loss_d_r & ~frame_sync_loss_in;

  interval_timer #(
    .CYCLES (REFRAME_CYCLES)
  ) u_reframe_window (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .start_in   (fs_gain),
    .idle_out   (window_idle)
  );

  // Reframe watch: flag only under maintenance, drop on CRC lock
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rf_state_r <= e1_rx_status_pkg::RF_IDLE;
    end else begin
      unique case (rf_state_r)
        e1_rx_status_pkg::RF_IDLE: begin
          if (fs_gain) begin
            rf_state_r <= e1_rx_status_pkg::RF_WAIT;
          end
        end
        e1_rx_status_pkg::RF_WAIT: begin
          // Lock or renewed loss ends the search quietly
          if (crc_locked_in || frame_sync_loss_in) begin
            rf_state_r <= e1_rx_status_pkg::RF_IDLE;
          end else if (window_idle) begin
            rf_state_r <= maint ? e1_rx_status_pkg::RF_FLAG
                                : e1_rx_status_pkg::RF_IDLE;
          end
        end
        e1_rx_status_pkg::RF_FLAG: begin
          if (crc_locked_in || !maint) begin
            rf_state_r <= e1_rx_status_pkg::RF_IDLE;
          end
        end
        default: begin
          rf_state_r <= e1_rx_status_pkg::RF_IDLE;  // Unused code
        end
      endcase
    end
  end

  // Byte assembly; status one and two are built from live state
  always_comb begin
    bytes.rx_nonalign_byte  = nonalign_r;
    bytes.phase_status      = phase_r;
    bytes.crc_error_tally   = tally_r;
    bytes.master_status_one = 8'h00;
    bytes.master_status_one[`S1_FRAME_LOSS]  = frame_sync_loss_in;
    bytes.master_status_one[`S1_MFRAME_LOSS] = multiframe_sync_loss_in;
    bytes.master_status_one[`S1_ALIGN_ERR]   = align_err_r;
    bytes.master_status_one[`S1_SLIP]        = slip_r;
    bytes.master_status_one[`S1_ALL_ONES]    = rx_all_ones_alarm_in;
    bytes.master_status_one[`S1_SIG_ONES]    = rx_sig_slot_all_ones_in;
    bytes.master_status_one[`S1_EXT_STATUS]  = ext_sample_r;
    bytes.master_status_two = 8'h00;
    bytes.master_status_two[`S2_SPARE15]     = spare15_r;
    bytes.master_status_two[`S2_SPARE13]     = spare13_r;
    bytes.master_status_two[`S2_SECOND_MARK] = marker_r;
    bytes.master_status_two[`S2_REFRAME]     =
      (rf_state_r == e1_rx_status_pkg::RF_FLAG) & maint & ~crc_locked_in;
    bytes.master_status_two[`S2_CRC_LOCK]    = ~crc_locked_in;
    bytes.master_status_two[`S2_PHASE_MSB]   = phase_msb_r;
  end

  // Serial output, loaded at each bus bit edge
  status_serializer u_serializer (
    .sys_clk_in    (sys_clk_in),
    .rst_n_in      (rst_n_in),
    .advance_in    (bit_rise),
    .pos_in        (pos_nxt),
    .bytes_in      (bytes),
    .stream_out    (control_out_stream_out),
    .stream_oe_out (control_out_stream_oe_out)
  );

endmodule

/* include/e1_rx_status_regs.svh */
// Constants of the receive status words: channels, field positions, resets, times.
// Assumes a 50 MHz system clock; times are turned into cycles by the top module.
`ifndef E1_RX_STATUS_REGS_SVH
`define E1_RX_STATUS_REGS_SVH

// Control output channels of the five status bytes
`define CH_NONALIGN      5'h11
`define CH_STATUS_ONE    5'h12
`define CH_PHASE         5'h13
`define CH_CRC_TALLY     5'h14
`define CH_STATUS_TWO    5'h15

// Field positions
`define MAINT_BIT        3
`define S1_FRAME_LOSS    7
`define S1_MFRAME_LOSS   6
`define S1_ALIGN_ERR     5
`define S1_SLIP          4
`define S1_ALL_ONES      3
`define S1_SIG_ONES      2
`define S1_EXT_STATUS    1
`define S2_SPARE15       7
`define S2_SPARE13       6
`define S2_SECOND_MARK   3
`define S2_REFRAME       2
`define S2_CRC_LOCK      1
`define S2_PHASE_MSB     0

// Expected alignment pattern in bits 6-0 and errors per toggle
`define ALIGN_PATTERN    7'h1b
`define ERR_TOGGLE_COUNT 5'h10

// Reset values
`define STATUS_ONE_RST   8'hc0
`define STATUS_TWO_RST   8'h02

// Times in milliseconds and the clock rate in kHz
`define CLK_KHZ          50000
`define ERR_HOLD_MS      128
`define CRC_MARKER_MS    8
`define REFRAME_MS       8
`define CRC_INTERVAL_MS  1000

`endif

/* include/e1_rx_status_pkg.sv */
// Types shared by the receive status word logic.
// Assumes the constants header is included by the design files.
package e1_rx_status_pkg;

  // The five status bytes, in channel order
  typedef struct packed {
    logic [7:0] rx_nonalign_byte;
    logic [7:0] master_status_one;
    logic [7:0] phase_status;
    logic [7:0] crc_error_tally;
    logic [7:0] master_status_two;
  } status_bytes_type;

  // CRC reframe watch states
  typedef enum logic [1:0] {
    RF_IDLE = 2'b00,
    RF_WAIT = 2'b01,
    RF_FLAG = 2'b10
  } reframe_state_type;

endpackage

/* hdl/interval_timer.sv */
// One-shot cycle timer: a start pulse arms it, idle_out rises when it runs out.
// Assumes start_in comes from logic on the same clock.
`timescale 1ns/1ps
module interval_timer #(
  parameter logic [31:0] CYCLES = 32'h1
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  input  wire logic start_in,
  output logic      idle_out
);

  logic [31:0] count_r;  // Cycles left

  // Idle from reset so the first use is not held off
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      count_r  <= 32'h0;
      idle_out <= 1'b1;
    end else if (start_in) begin
      count_r  <= CYCLES - 32'h1;
      idle_out <= 1'b0;
    end else if (!idle_out) begin
      // Count down, then fall idle on zero
      if (count_r == 32'h0) begin
        idle_out <= 1'b1;
      end else begin
        count_r <= count_r - 32'h1;
      end
    end
  end

endmodule

/* hdl/status_serializer.sv */
// Shifts the five status bytes onto the control output stream.
// Assumes pos_in is the bus position about to start, given with advance_in.
`timescale 1ns/1ps
`include "e1_rx_status_regs.svh"
module status_serializer (
  input  wire logic                                sys_clk_in,
  input  wire logic                                rst_n_in,
  input  wire logic                                advance_in,
  input  wire logic [7:0]                          pos_in,
  input  wire e1_rx_status_pkg::status_bytes_type  bytes_in,
  output logic                                     stream_out,
  output logic                                     stream_oe_out
);

  logic [7:0] byte_sel;  // Byte of the channel about to go out

  // Channel decode for the enable only; the data byte has its own case
  function automatic logic owned(input logic [4:0] ch);
    owned = (ch >= `CH_NONALIGN) && (ch <= `CH_STATUS_TWO);
  endfunction

  // Pick the byte for the coming channel
  always_comb begin
    unique case (pos_in[7:3])
      `CH_NONALIGN:   byte_sel = bytes_in.rx_nonalign_byte;
      `CH_STATUS_ONE: byte_sel = bytes_in.master_status_one;
      `CH_PHASE:      byte_sel = bytes_in.phase_status;
      `CH_CRC_TALLY:  byte_sel = bytes_in.crc_error_tally;
      `CH_STATUS_TWO: byte_sel = bytes_in.master_status_two;
      default:        byte_sel = 8'hff;  // Idle ones elsewhere
    endcase
  end

  // Most significant bit leaves first; drive only our channels
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      stream_out    <= 1'b1;
      stream_oe_out <= 1'b0;
    end else if (advance_in) begin
      stream_out    <= byte_sel[3'h7 - pos_in[2:0]];
      stream_oe_out <= owned(pos_in[7:3]);
    end
  end

endmodule

/* verif/e1_rx_status_words_sva.sv */
// Checker on the control stream of the receive status words.
// Assumes the bus bit clock is far slower than sys_clk_in.
`timescale 1ns/1ps
module e1_rx_status_words_sva (
  input wire logic       sys_clk_in,
  input wire logic       rst_n_in,
  input wire logic       bus_bit_clk_in,
  input wire logic       bus_frame_pulse_n_in,
  input wire logic       frame_sync_loss_in,
  input wire logic       multiframe_sync_loss_in,
  input wire logic       rx_all_ones_alarm_in,
  input wire logic       rx_sig_slot_all_ones_in,
  input wire logic       crc_locked_in,
  input wire logic [7:0] control_word_three_in,
  input wire logic       control_out_stream_out,
  input wire logic       control_out_stream_oe_out
);
  logic [2:0] bclk_r;   // Bit clock synchroniser
  logic [2:0] fp_r;     // Frame pulse synchroniser
  logic [7:0] pos_r;    // Bus position of the bit in flight
  logic [3:0] age_r;    // Cycles since that bit began
  logic       framed_r; // A frame pulse has been seen
  logic       mid;      // Middle of a bit, where outputs have settled
  logic       so;       // Short names of the stream pins
  logic       oe;
  assign mid = framed_r && (age_r == 4'h4);
  assign so = control_out_stream_out;
  assign oe = control_out_stream_oe_out;

  // Synchronisers, two flops as the design has
  always_ff @(posedge sys_clk_in) begin
    bclk_r <= {bclk_r[1:0], bus_bit_clk_in};
    fp_r   <= {fp_r[1:0], bus_frame_pulse_n_in};
  end

  // Own bit position; mid-bit sampling hides a cycle of latency skew
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pos_r    <= 8'h00;
      age_r    <= 4'h0;
      framed_r <= 1'b0;
    end else if (bclk_r[1] && !bclk_r[2]) begin
      age_r    <= 4'h0;
      framed_r <= framed_r | ~fp_r[1];
      pos_r    <= fp_r[1] ? pos_r + 8'h01 : 8'h00;
    end else if (age_r != 4'hf) begin
      age_r <= age_r + 4'h1;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // Level bits are checked only where the input held long enough to be loaded
  chk_reset_idle: assert property (disable iff (1'b0) (!rst_n_in) [*2] |-> so && !oe)
    else $error("Stream not idle in reset");
  chk_oe_window: assert property (mid |-> oe == (pos_r inside {[8'h88:8'haf]}))
    else $error("Enable outside channels 17 to 21");
  chk_idle_high: assert property (mid ##0 !oe |-> so)
    else $error("Stream low while not driven");
  chk_frame_loss: assert property (mid && pos_r == 8'h90 &&
    $past(frame_sync_loss_in, 24) == frame_sync_loss_in |-> so == frame_sync_loss_in)
    else $error("Frame loss bit wrong");
  chk_mframe_loss: assert property ($stable(multiframe_sync_loss_in) [*8] ##0
    (mid && pos_r == 8'h91) |-> so == multiframe_sync_loss_in)
    else $error("Multiframe loss bit wrong");
  chk_all_ones: assert property (mid && pos_r == 8'h94 &&
    $past(rx_all_ones_alarm_in, 56) == rx_all_ones_alarm_in |-> so == rx_all_ones_alarm_in)
    else $error("All ones bit wrong");
  chk_slot_ones: assert property (mid && pos_r == 8'h95 &&
    $past(rx_sig_slot_all_ones_in, 56) == rx_sig_slot_all_ones_in
    |-> so == rx_sig_slot_all_ones_in) else $error("Slot ones bit wrong");
  chk_unused_zero: assert property (mid && pos_r inside {8'h97, 8'haa, 8'hab} |-> !so)
    else $error("Unused bit not zero");
  chk_crc_lock: assert property (mid && pos_r == 8'hae &&
    $past(crc_locked_in, 64) == crc_locked_in |-> so != crc_locked_in)
    else $error("CRC lock bit wrong");
  chk_reframe_off: assert property (mid && pos_r == 8'had && !control_word_three_in[3] &&
    !$past(control_word_three_in[3], 64) |-> !so) else $error("Reframe set without maint");

  cover property (mid && pos_r == 8'h88 && oe);
  cover property (mid && pos_r == 8'hae && !so);
  cover property ($fell(oe));
endmodule

/* verif/host_stream_reader.sv */
// Host model: makes bus bit clock and frame pulse, reads channels 17-21.
// Assumes 160 ns bus bits; bytes appear after channel 21 is read.
`timescale 1ns/1ps
module host_stream_reader (
  input  wire logic                          stream_in,
  input  wire logic                          stream_oe_in,
  output logic                               bit_clk_out,
  output logic                               frame_pulse_n_out,
  output logic [7:0]                         pos_out,
  output e1_rx_status_pkg::status_bytes_type bytes_out,
  output logic [15:0]                        frames_out
);
  logic [39:0] shift_r; // Bits of channels 17-21 as they arrive
  logic [7:0]  p;       // Position of the bit now on the bus

  // Free running bus: rise, fall at 80 ns, sample at 120 ns
  initial begin
    bit_clk_out = 1'b0;
    frame_pulse_n_out = 1'b1;
    pos_out = 8'h00;
    bytes_out = 40'h0;
    frames_out = 16'h0000;
    shift_r = 40'h0;
    p = 8'hfe;
    #7;
    forever begin
      bit_clk_out = 1'b1;
      p = p + 8'h01;
      #80;
      bit_clk_out = 1'b0;
      pos_out = p;
      // Pulse straddles the rise that opens bit 0
      frame_pulse_n_out = (p != 8'hff);
      #40;
      // An undriven line reads unknown, never a lucky bit
      if (p >= 8'h88 && p <= 8'haf) begin
        shift_r = {shift_r[38:0], stream_oe_in ? stream_in : 1'bx};
      end
      if (p == 8'haf) begin
        bytes_out = shift_r;
        frames_out = frames_out + 16'h0001;
      end
      #40;
    end
  end
endmodule

/* verif/e1_rx_status_words_tb.sv */
// Testbench: drives framer inputs, reads the status bytes through the host model.
// Assumes short hold, marker, reframe and second counts set at the instance.
`timescale 1ns/1ps
module e1_rx_status_words_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  lv = 5'b11000;  // Loss, mf loss, all ones, slot ones, external
  logic        crc_lk = 1'b0;  // CRC multiframe lock
  logic [2:0]  pls = 3'b000;   // Slip, CRC error, multiframe pulses
  logic [7:0]  ts0_b = 8'h00;  // Timeslot zero byte and qualifiers
  logic        ts0_v = 1'b0;
  logic        ts0_a = 1'b0;
  logic [1:0]  sp = 2'b00;     // Spare bits of frames 15 and 13
  logic [7:0]  cw3 = 8'h00;    // Control word three
  logic        e8k = 1'b0;     // Extracted 8 kHz
  logic        bclk;
  logic        fp_n;
  logic        so;
  logic        oe;
  logic [7:0]  pos;
  logic [15:0] frames;
  logic        e_err = 1'b0;   // Expected toggle bits
  logic        e_slip = 1'b0;
  int          failures = 0;
  int          n_checks = 0;
  e1_rx_status_pkg::status_bytes_type rd;
  e1_rx_status_pkg::status_bytes_type e;

  always #10 clk = ~clk;

  e1_rx_status_words #(.ERR_HOLD_CYCLES(32'h2328), .MARKER_CYCLES(32'h8),
    .REFRAME_CYCLES(32'ha), .SECOND_CYCLES(32'hbb8)) dut_u (
    .sys_clk_in(clk), .rst_n_in(rst_n), .bus_bit_clk_in(bclk),
    .bus_frame_pulse_n_in(fp_n), .extracted_8k_in(e8k), .external_status_in(lv[0]),
    .ts0_byte_in(ts0_b), .ts0_valid_in(ts0_v), .ts0_is_align_in(ts0_a),
    .frame_sync_loss_in(lv[4]), .multiframe_sync_loss_in(lv[3]), .slip_pulse_in(pls[0]),
    .rx_all_ones_alarm_in(lv[2]), .rx_sig_slot_all_ones_in(lv[1]), .crc_locked_in(crc_lk),
    .crc_error_pulse_in(pls[1]), .rx_multiframe_pulse_in(pls[2]),
    .spare_bit_frame15_in(sp[1]), .spare_bit_frame13_in(sp[0]),
    .control_word_three_in(cw3), .control_out_stream_out(so),
    .control_out_stream_oe_out(oe));

  host_stream_reader host_u (.stream_in(so), .stream_oe_in(oe), .bit_clk_out(bclk),
    .frame_pulse_n_out(fp_n), .pos_out(pos), .bytes_out(rd), .frames_out(frames));

  task automatic stop_test();
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Wait for the next capture; inputs change just after one, so it follows them
  task automatic frame();
    logic [15:0] f;
    int          k;
    f = frames;
    k = 0;
    while (frames == f && k < 6000) begin
      @(posedge clk);
      k++;
    end
    if (k == 6000) begin
      failures++;
      stop_test();
    end
  endtask

  // Compare all five bytes; the second marker bit is left out as free running
  task automatic chk();
    logic [39:0] g;
    logic [39:0] x;
    frame();
    e.master_status_one = {lv[4:3], e_err, e_slip, lv[2:0], 1'b0};
    e.master_status_two[1] = ~crc_lk;
    g = rd & 40'hfffffffff7;
    x = e & 40'hfffffffff7;
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic ts0(input logic [7:0] b, input logic al, input int n);
    repeat (n) begin
      ts0_b <= b;
      ts0_a <= al;
      ts0_v <= 1'b1;
      @(posedge clk);
      ts0_v <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic pulse(input int k, input int n);
    repeat (n) begin
      pls[k] <= 1'b1;
      @(posedge clk);
      pls[k] <= 1'b0;
      @(posedge clk);
    end
  endtask

  // Raise the 8 kHz edge in the second half of bus bit p
  task automatic phase(input logic [7:0] p);
    int k;
    k = 0;
    while (pos !== p && k < 6000) begin
      @(posedge clk);
      k++;
    end
    if (k == 6000) begin
      failures++;
      stop_test();
    end
    e8k <= 1'b1;
    repeat (4) @(posedge clk);
    e8k <= 1'b0;
    e.phase_status = p;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    e = 40'h00c0000002;
    chk();
    for (int i = 0; i < 2; i++) begin
      ts0(8'h5a ^ {8{i[0]}}, 1'b0, 1);
      ts0(8'h9b, 1'b1, 1);
      e.rx_nonalign_byte = 8'h5a ^ {8{i[0]}};
      chk();
    end
    for (int i = 0; i < 4; i++) begin
      lv <= 5'h15 ^ (5'h1f & {5{i[0]}}) ^ (5'h1f & {5{i[1]}});
      chk();
    end
    lv <= 5'b00000;
    pulse(0, 3);
    e_slip = 1'b1;
    chk();
    // Fifteen errored alignment bytes; non-alignment ones must not add
    ts0(8'h00, 1'b1, 15);
    ts0(8'h00, 1'b0, 4);
    e.rx_nonalign_byte = 8'h00;
    chk();
    ts0(8'h80, 1'b1, 1);
    e_err = 1'b1;
    chk();
    ts0(8'h00, 1'b1, 16);
    chk();
    frame();
    frame();
    e_err = 1'b0;
    chk();
    pulse(1, 258);
    e.crc_error_tally = 8'h02;
    chk();
    cw3 <= 8'h08;
    frame();
    e.crc_error_tally = 8'h00;
    chk();
    lv <= 5'b10000;
    repeat (2) @(posedge clk);
    lv <= 5'b00000;
    e.master_status_two[2] = 1'b1;
    chk();
    crc_lk <= 1'b1;
    e.master_status_two[2] = 1'b0;
    chk();
    sp <= 2'b10;
    pulse(2, 1);
    e.master_status_two[7:6] = 2'b10;
    chk();
    sp <= 2'b01;
    chk();
    phase(8'h5d);
    chk();
    phase(8'hfa);
    phase(8'h03);
    e.master_status_two[0] = 1'b1;
    chk();
    stop_test();
  end
endmodule

bind e1_rx_status_words e1_rx_status_words_sva chk_u (.*);
